//--- core/pwm_art_defines.svh
// register offsets, field positions and reset values for the pwm auto-reload timer
// assumes byte addresses indexed as 4 x printed offset on a 32-bit apb bus
`ifndef PWM_ART_DEFINES_SVH
`define PWM_ART_DEFINES_SVH
// printed offsets are register indices
`define IDX_DUTY3 8'h73
`define IDX_DUTY2 8'h74
`define IDX_DUTY1 8'h75
`define IDX_DUTY0 8'h76
`define IDX_PWMCTL 8'h77
`define IDX_CSR 8'h78
`define IDX_CNT 8'h79
`define IDX_RELOAD 8'h7A
`define IDX_CAPCSR 8'h7B
`define IDX_CAP1 8'h7C
`define IDX_CAP2 8'h7D
// control/status fields
`define CSR_EXTCLK 7
`define CSR_PRESC_HI 6
`define CSR_PRESC_LO 4
`define CSR_RUN 3
`define CSR_FORCE 2
`define CSR_OVIE 1
`define CSR_OVF 0
// capture control/status fields
`define CAP_EDGE_LO 4
`define CAP_IE_LO 2
`define CAP_FLAG_LO 0
`define RESET_BYTE 8'h00
`define COUNT_TOP 8'hFF
`endif

//--- core/pwm_art_pkg.sv
// types for the pwm auto-reload timer
// assumes nothing beyond a systemverilog compiler
package pwm_art_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [0:0] {
        APB_SETUP = 1'b0,
        APB_ACCESS = 1'b1
    } apb_phase_t;
endpackage

//--- core/pwm_art_timer.sv
// pwm auto-reload timer: 8-bit counter, prescaler, four pwm channels, two captures, apb slave
// assumes an apb master on clock; pins arrive asynchronous and pass three flip-flops
`include "pwm_art_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module pwm_art_timer
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic extClock,
    input wire logic [1:0] captureInputs,
    output logic [3:0] pwmOutputs,
    output logic [3:0] pwmOutputEnables,
    output logic overflowIrq,
    output logic [1:0] captureIrq
);

    pwm_art_pkg::byte_t duty [4];
    pwm_art_pkg::byte_t compareShadow [4];
    pwm_art_pkg::byte_t pwmOutputControl;
    pwm_art_pkg::byte_t counter;
    pwm_art_pkg::byte_t reloadValue;
    pwm_art_pkg::byte_t captureValue [2];
    logic extClockSelect;
    logic [2:0] prescaleSelect;
    logic counterRun;
    logic overflowIrqEnable;
    logic overflowFlag;
    logic [1:0] captureEdge;
    logic [1:0] captureIrqEnable;
    logic [1:0] captureFlag;
    logic [6:0] prescaler;
    logic [2:0] extSync;
    logic extState;
    logic [2:0] capSync [2];
    logic [1:0] capState;
    pwm_art_pkg::apb_phase_t phase;
    logic [1:0] readFlags;

    // decode a bus address into its printed index; returns 0 when unaligned or out of range
    function automatic logic [7:0] regIndex(input logic [11:0] addr);
        return (addr[1:0] != 2'b00 || addr[11:10] != 2'b00) ? 8'h00 : addr[9:2];
    endfunction
    // pwm level before the output enable: polarity applied live to the compare result
    function automatic logic pwmLevel(input logic [7:0] cnt, input logic [7:0] cmp, input logic pol);
        return (cnt <= cmp) ^ pol;
    endfunction

    logic [7:0] index;
    logic mapped;
    logic writeStrobe;
    logic readStrobe;
    logic extEdge;
    logic tick;
    logic overflow;
    logic [1:0] captureEvent;
    logic [31:0] next_prdata;
    logic [6:0] prescaleMask;

    assign index = regIndex(paddr);
    // duty..capture2 occupy a contiguous block of indices
    assign mapped = (index >= `IDX_DUTY3) && (index <= `IDX_CAP2);
    assign writeStrobe = psel && penable && pwrite && mapped;
    assign readStrobe = psel && penable && !pwrite && mapped;
    // external clock counts once the second and third stages agree on a new level
    assign extEdge = (extSync[1] == extSync[2]) && (extSync[2] != extState);
    // mask of prescaler bits that must be all ones for a tap of 2^n
    assign prescaleMask = 7'((8'h01 << prescaleSelect) - 8'h01);
    assign tick = counterRun && (extClockSelect ? extEdge : 1'b1)
        && ((prescaler & prescaleMask) == prescaleMask);
    assign overflow = tick && (counter == `COUNT_TOP) // software loads pre-empt the rollover
        && !(writeStrobe && (index == `IDX_CNT || (index == `IDX_CSR && pwdata[`CSR_FORCE])));
    // capture pin edges of the chosen polarity
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            captureEvent[i] = (capSync[i][1] == capSync[i][2]) && (capSync[i][2] != capState[i])
                && (capSync[i][2] == captureEdge[i]);
        end
    end

    // pin synchronisers and accepted levels
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            extSync <= 3'h0;
            extState <= 1'b0;
            capSync[0] <= 3'h0;
            capSync[1] <= 3'h0;
            capState <= 2'h0;
        end
        else
        begin
            extSync <= {extSync[1:0], extClock};
            if (extSync[1] == extSync[2])
            begin
                extState <= extSync[2];
            end
            for (int i = 0; i < 2; i++)
            begin
                capSync[i] <= {capSync[i][1:0], captureInputs[i]};
                if (capSync[i][1] == capSync[i][2])
                begin
                    capState[i] <= capSync[i][2];
                end
            end
        end
    end
    // apb: one wait-free access phase, errors on unmapped addresses
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            phase <= pwm_art_pkg::APB_SETUP;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            case (phase)
                pwm_art_pkg::APB_SETUP:
                begin
                    if (psel && !penable)
                    begin
                        phase <= pwm_art_pkg::APB_ACCESS;
                        pready <= 1'b1;
                        pslverr <= !mapped;
                    end
                end
                default: // the access phase always returns to setup
                begin
                    phase <= pwm_art_pkg::APB_SETUP;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
            endcase
        end
    end
    // read data mux, registered at setup so it is valid in the access phase
    always_comb
    begin
        next_prdata = 32'h0;
        case (index)
            `IDX_DUTY3: next_prdata[7:0] = duty[3];
            `IDX_DUTY2: next_prdata[7:0] = duty[2];
            `IDX_DUTY1: next_prdata[7:0] = duty[1];
            `IDX_DUTY0: next_prdata[7:0] = duty[0];
            `IDX_PWMCTL: next_prdata[7:0] = pwmOutputControl;
            `IDX_CSR: next_prdata[7:0] = {extClockSelect, prescaleSelect, counterRun, 1'b0,
                overflowIrqEnable, overflowFlag};
            `IDX_CNT: next_prdata[7:0] = counter;
            `IDX_RELOAD: next_prdata[7:0] = reloadValue;
            `IDX_CAPCSR: next_prdata[7:0] = {2'b00, captureEdge, captureIrqEnable, captureFlag};
            `IDX_CAP1: next_prdata[7:0] = captureValue[0];
            `IDX_CAP2: next_prdata[7:0] = captureValue[1];
            default: next_prdata = 32'h0;
        endcase
    end
    // read data and the capture flags it reports, latched together so a read clears only what it saw
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            prdata <= 32'h0;
            readFlags <= 2'h0;
        end
        else if (psel && !penable && !pwrite)
        begin
            prdata <= next_prdata;
            readFlags <= captureFlag;
        end
    end
    // software-only configuration registers
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < 4; i++)
            begin
                duty[i] <= `RESET_BYTE;
            end
            pwmOutputControl <= `RESET_BYTE;
            reloadValue <= `RESET_BYTE;
            extClockSelect <= 1'b0;
            prescaleSelect <= 3'h0;
            counterRun <= 1'b0;
            overflowIrqEnable <= 1'b0;
            captureEdge <= 2'h0;
            captureIrqEnable <= 2'h0;
        end
        else if (writeStrobe)
        begin
            case (index)
                `IDX_DUTY3: duty[3] <= pwdata[7:0];
                `IDX_DUTY2: duty[2] <= pwdata[7:0];
                `IDX_DUTY1: duty[1] <= pwdata[7:0];
                `IDX_DUTY0: duty[0] <= pwdata[7:0];
                `IDX_PWMCTL: pwmOutputControl <= pwdata[7:0];
                `IDX_RELOAD: reloadValue <= pwdata[7:0];
                `IDX_CSR:
                begin
                    extClockSelect <= pwdata[`CSR_EXTCLK];
                    prescaleSelect <= pwdata[`CSR_PRESC_HI:`CSR_PRESC_LO];
                    counterRun <= pwdata[`CSR_RUN];
                    overflowIrqEnable <= pwdata[`CSR_OVIE];
                end
                `IDX_CAPCSR:
                begin
                    captureEdge <= pwdata[`CAP_EDGE_LO+1:`CAP_EDGE_LO];
                    captureIrqEnable <= pwdata[`CAP_IE_LO+1:`CAP_IE_LO];
                end
                default: ;
            endcase
        end
    end
    // counter and prescaler; software loads win over counting
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            counter <= `RESET_BYTE;
            prescaler <= 7'h0;
        end
        else if (writeStrobe && index == `IDX_CSR && pwdata[`CSR_FORCE])
        begin
            counter <= reloadValue;
            prescaler <= 7'h0;
        end
        else if (writeStrobe && index == `IDX_CNT)
        begin
            counter <= pwdata[7:0];
            prescaler <= 7'h0;
        end
        else if (counterRun && (!extClockSelect || extEdge))
        begin
            prescaler <= tick ? 7'h0 : 7'(prescaler + 7'h1);
            if (overflow)
            begin
                counter <= reloadValue;
            end
            else if (tick)
            begin
                counter <= 8'(counter + 8'h01);
            end
        end
    end

    // compare shadows take the duty values only on overflow
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < 4; i++)
            begin
                compareShadow[i] <= `RESET_BYTE;
            end
        end
        else if (overflow)
        begin
            for (int i = 0; i < 4; i++)
            begin
                compareShadow[i] <= duty[i];
            end
        end
    end

    // overflow flag: set beats the clearing read
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            overflowFlag <= 1'b0;
        end
        else if (overflow)
        begin
            overflowFlag <= 1'b1;
        end
        else if (readStrobe && index == `IDX_CSR && prdata[`CSR_OVF]) // clear only a flag the read reported
        begin
            overflowFlag <= 1'b0;
        end
    end

    // capture latch is blocked while its flag is set
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            captureFlag <= 2'h0;
            captureValue[0] <= `RESET_BYTE;
            captureValue[1] <= `RESET_BYTE;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (captureEvent[i] && !captureFlag[i])
                begin
                    captureFlag[i] <= 1'b1;
                    captureValue[i] <= counter;
                end
                else if (readStrobe && index == 8'(`IDX_CAP1 + i) && readFlags[i])
                begin
                    captureFlag[i] <= 1'b0;
                end
            end
        end
    end
    // outputs; with the counter rolling over this cycle the pins show the overflow level
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            pwmOutputs <= 4'h0;
            pwmOutputEnables <= 4'h0;
            overflowIrq <= 1'b0;
            captureIrq <= 2'h0;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                pwmOutputs[i] <= pwmOutputControl[4+i] && (overflow ? !pwmOutputControl[i]
                    : pwmLevel(counter, compareShadow[i], pwmOutputControl[i]));
            end
            pwmOutputEnables <= pwmOutputControl[7:4];
            overflowIrq <= (overflowFlag || overflow) && overflowIrqEnable;
            captureIrq <= captureFlag & captureIrqEnable;
        end
    end

    AST_FORCE_READS_ZERO: assert property (@(posedge clock) disable iff (!rstn)
        psel && !penable && !pwrite && index == `IDX_CSR |=> prdata[`CSR_FORCE] == 1'b0)
        else $error("force bit read as one");
    AST_OVF_SET: assert property (@(posedge clock) disable iff (!rstn)
        overflow |=> overflowFlag && counter == $past(reloadValue))
        else $error("overflow did not reload and flag");
    AST_IRQ_GATE: assert property (@(posedge clock) disable iff (!rstn)
        overflowIrq |-> $past(overflowIrqEnable))
        else $error("overflow irq without enable");
    AST_OVF_CLEAR: assert property (@(posedge clock) disable iff (!rstn)
        readStrobe && index == `IDX_CSR && prdata[`CSR_OVF] && !overflow |=> !overflowFlag)
        else $error("status read did not clear flag");
    AST_FROZEN: assert property (@(posedge clock) disable iff (!rstn)
        !counterRun && !writeStrobe |=> $stable(counter) && $stable(prescaler))
        else $error("counter moved while stopped");
    AST_ENABLE_PIN: assert property (@(posedge clock) disable iff (!rstn)
        ##1 (pwmOutputEnables == $past(pwmOutputControl[7:4])))
        else $error("output enables wrong");
    AST_CAP_RSVD: assert property (@(posedge clock) disable iff (!rstn)
        psel && !penable && !pwrite && index == `IDX_CAPCSR |=> prdata[7:6] == 2'b00)
        else $error("reserved capture bits nonzero");
    AST_CAP_HOLD: assert property (@(posedge clock) disable iff (!rstn)
        captureFlag[0] |=> $stable(captureValue[0]))
        else $error("capture overwritten while flagged");
    AST_SHADOW: assert property (@(posedge clock) disable iff (!rstn)
        !overflow |=> $stable(compareShadow[0]))
        else $error("compare shadow changed without overflow");

endmodule

`default_nettype wire

//--- sim/pwm_autoreload_timer_regs_tb.sv
// directed testbench for the pwm auto-reload timer, driven through apb tasks
// assumes the timer answers each apb access in one cycle and all pins are driven here
`include "pwm_art_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module pwm_autoreload_timer_regs_tb;
    logic clock;
    logic rstn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic extClock;
    logic [1:0] captureInputs;
    logic [3:0] pwmOutputs;
    logic [3:0] pwmOutputEnables;
    logic overflowIrq;
    logic [1:0] captureIrq;
    logic [31:0] rdata;
    logic rerr;
    int fails;
    int cmpCount;

    pwm_art_timer dut
    (
        .clock(clock),
        .rstn(rstn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .extClock(extClock),
        .captureInputs(captureInputs),
        .pwmOutputs(pwmOutputs),
        .pwmOutputEnables(pwmOutputEnables),
        .overflowIrq(overflowIrq),
        .captureIrq(captureIrq)
    );

    // cpu clock, 50 ns period
    always #25 clock = ~clock;

    // verdict and end of run
    task automatic end_sim();
        if (fails == 0 && cmpCount > 0)
        begin
            $display("No errors found");
        end
        else
        begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // compare seen against expected, count and report
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one apb transfer: setup, access held until pready, release after that edge
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        @(posedge clock);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'h1;
        n = 0;
        // values read right at an edge are those the slave sampled there
        @(posedge clock);
        while (pready !== 1'h1 && n < 20)
        begin
            @(posedge clock);
            n++;
        end
        if (n == 20)
        begin
            fails++;
            end_sim();
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] idx, input pwm_art_pkg::byte_t d);
        apb(1'h1, idx, {24'h000000, d});
    endtask

    task automatic rd(input logic [7:0] idx, input string name, input pwm_art_pkg::byte_t exp);
        apb(1'h0, idx, 32'h00000000);
        check(name, rdata, {24'h000000, exp});
    endtask

    // let registered outputs settle
    task automatic settle();
        repeat (3) @(posedge clock);
        #1;
    endtask

    // bounded wait for the overflow request
    task automatic wait_irq();
        int n;
        n = 0;
        while (overflowIrq !== 1'h1 && n < 400)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        if (n == 400)
        begin
            fails++;
            end_sim();
        end
    endtask

    // count external clock changes with a given prescale and run state
    task automatic ext_count(input logic [2:0] presc, input int toggles, input logic runBit,
        input pwm_art_pkg::byte_t exp);
        wr(`IDX_CSR, {1'h1, presc, 4'h0});
        wr(`IDX_CNT, 8'h00);
        wr(`IDX_CSR, {1'h1, presc, runBit, 3'h0});
        repeat (toggles)
        begin
            repeat (8) @(posedge clock);
            extClock <= ~extClock;
        end
        repeat (8) @(posedge clock);
        wr(`IDX_CSR, {1'h1, presc, 4'h0});
        rd(`IDX_CNT, "ext_count", exp);
    endtask

    // main sequence
    initial
    begin
        clock = 1'h0;
        rstn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        extClock = 1'h0;
        captureInputs = 2'h0;
        fails = 0;
        cmpCount = 0;
        repeat (10) @(posedge clock);
        rstn <= 1'h1;
        // reset values across the whole map
        for (int i = 'h73; i <= 'h7D; i++)
        begin
            rd(i[7:0], "reset_value", 8'h00);
        end
        // distinct pattern into every plain read/write register
        for (int i = 'h73; i <= 'h7A; i++)
        begin
            if (i != 'h78)
            begin
                wr(i[7:0], i[7:0] ^ 8'hA5);
            end
        end
        for (int i = 'h73; i <= 'h7A; i++)
        begin
            if (i != 'h78)
            begin
                rd(i[7:0], "readback", i[7:0] ^ 8'hA5);
            end
        end
        apb(1'h0, 8'h72, 32'h00000000);
        check("unmapped_err", {31'h0, rerr}, 32'h1);
        check("unmapped_data", rdata, 32'h0);
        // force reload reads zero and loads the reload value
        wr(`IDX_RELOAD, 8'h40);
        wr(`IDX_CSR, 8'h04);
        rd(`IDX_CSR, "force_reads_zero", 8'h00);
        check("mapped_err", {31'h0, rerr}, 32'h0);
        rd(`IDX_CNT, "force_loads", 8'h40);
        // pwm: shadows stay zero until overflow
        wr(`IDX_RELOAD, 8'h00);
        wr(`IDX_PWMCTL, 8'hF0);
        wr(`IDX_DUTY0, 8'h80);
        wr(`IDX_DUTY1, 8'h40);
        wr(`IDX_DUTY2, 8'h60);
        wr(`IDX_DUTY3, 8'h5F);
        wr(`IDX_CNT, 8'h60);
        settle();
        check("pwm_before_ovf", {28'h0, pwmOutputs}, 32'h0);
        check("pwm_enables", {28'h0, pwmOutputEnables}, 32'hF);
        wr(`IDX_PWMCTL, 8'hFF);
        settle();
        check("pwm_polarity", {28'h0, pwmOutputs}, 32'hF);
        wr(`IDX_PWMCTL, 8'hF0);
        // overflow at divide by 128 to load the shadows
        wr(`IDX_CNT, 8'hFF);
        wr(`IDX_CSR, 8'h7A);
        wait_irq();
        wr(`IDX_CSR, 8'h72);
        rd(`IDX_CSR, "ovf_set", 8'h73);
        rd(`IDX_CNT, "reload_zero", 8'h00);
        wr(`IDX_CNT, 8'h60);
        settle();
        check("pwm_compare", {28'h0, pwmOutputs}, 32'h5);
        wr(`IDX_PWMCTL, 8'h50);
        settle();
        check("pwm_part_out", {28'h0, pwmOutputs}, 32'h5);
        check("pwm_part_en", {28'h0, pwmOutputEnables}, 32'h5);
        wr(`IDX_PWMCTL, 8'hAF);
        settle();
        check("pwm_inv_out", {28'h0, pwmOutputs}, 32'hA);
        check("pwm_inv_en", {28'h0, pwmOutputEnables}, 32'hA);
        // overflow flag and interrupt enable
        wr(`IDX_RELOAD, 8'hF0);
        wr(`IDX_CNT, 8'hF0);
        wr(`IDX_CSR, 8'h08);
        repeat (40) @(posedge clock);
        #1;
        check("irq_masked", {31'h0, overflowIrq}, 32'h0);
        wr(`IDX_CSR, 8'h0A);
        settle();
        check("irq_enabled", {31'h0, overflowIrq}, 32'h1);
        wr(`IDX_CSR, 8'h02);
        rd(`IDX_CSR, "ovf_flag", 8'h03);
        rd(`IDX_CSR, "ovf_cleared", 8'h02);
        settle();
        check("irq_cleared", {31'h0, overflowIrq}, 32'h0);
        apb(1'h0, `IDX_CNT, 32'h00000000);
        check("count_wraps", {31'h0, rdata[7:0] >= 8'hF0}, 32'h1);
        // captures on a stopped counter
        wr(`IDX_RELOAD, 8'h00);
        wr(`IDX_CNT, 8'h33);
        wr(`IDX_CAPCSR, 8'hFF);
        rd(`IDX_CAPCSR, "cap_reserved", 8'h3C);
        wr(`IDX_CAPCSR, 8'h14);
        @(posedge clock);
        captureInputs <= 2'h3;
        settle();
        settle();
        check("cap_irq_rise", {30'h0, captureIrq}, 32'h1);
        rd(`IDX_CAPCSR, "cap_rise", 8'h15);
        wr(`IDX_CNT, 8'h44);
        @(posedge clock);
        captureInputs <= 2'h0;
        settle();
        settle();
        rd(`IDX_CAPCSR, "cap_fall", 8'h17);
        check("cap_irq_masked", {30'h0, captureIrq}, 32'h1);
        rd(`IDX_CAP1, "cap1_value", 8'h33);
        rd(`IDX_CAPCSR, "cap1_flag_clr", 8'h16);
        settle();
        check("cap_irq_clr", {30'h0, captureIrq}, 32'h0);
        rd(`IDX_CAP2, "cap2_value", 8'h44);
        wr(`IDX_CAP1, 8'hAA);
        rd(`IDX_CAP1, "cap1_read_only", 8'h33);
        // external clock events through the prescaler
        ext_count(3'h0, 10, 1'h1, 8'h0A);
        ext_count(3'h1, 8, 1'h1, 8'h04);
        ext_count(3'h2, 8, 1'h1, 8'h02);
        ext_count(3'h0, 6, 1'h0, 8'h00);
        end_sim();
    end
endmodule

`default_nettype wire
